/* File: hw/sfs_frame_sequencer.sv */
`timescale 1ns/100ps
// How it works
// - Idle with polarity zero: clock low, select high, data out low.
// - Master drives the clock pad; slave leaves it undriven.
// - Enabled master with pending word pulls select low, drives data out.
// - Phase zero: first bit half period after select falls, first edge after another half.
// - Polarity zero phase zero: sample on rising, change on falling.
// - Single word: select rises one clock period after the last capture.
// - Phase zero back to back: select pulses high between words.
// - Continuous end: select idles one period after the final capture.
// - Polarity zero phase one: half period after select, first bit and rising edge.
// - Polarity zero phase one: sample on falling, change on rising.
// - Phase one back to back: select stays low, ends as single word.
// - Idle with polarity one: clock high, select high, data out low.
// - Polarity one phase zero: first edge falls; sample falling, change rising.
// - Polarity one phase one: first edge falls; sample rising, change falling.
// - Words of four to sixteen bits, most significant bit first.
// - Polarity and phase come from two software control bits.
module sfs_frame_sequencer
#(
  parameter int WORD_W = sfs_pkg::WORD_MAX
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [sfs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sfs_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serialClockPinIn,
  output logic serialClockPinOut,
  output logic serialClockPinOe,
  input wire logic frameSelectPinInN,
  output logic frameSelectPinOutN,
  output logic frameSelectPinOe,
  output logic serialOutPin,
  output logic serialOutPinOe,
  input wire logic serialInPin
);
  localparam int LW = sfs_pkg::LEN_W;

  sfs_pin_if pins();

  logic [31:0] ctrl_r;
  logic [7:0] half_r;
  logic [WORD_W-1:0] txWord_r;
  logic [WORD_W-1:0] shWord_r;
  logic [WORD_W-1:0] rxShift_r;
  logic [WORD_W-1:0] rxData_r;
  logic txValid_r;
  logic rxValid_r;
  sfs_pkg::sfs_state_t state_r;
  logic [7:0] halfCnt_r;
  logic [LW+1:0] edgeCnt_r;
  logic tailCnt_r;
  logic sclk_r;
  logic fssN_r;
  logic serialOut_r;
  logic [LW-1:0] sOutIdx_r;
  logic [LW-1:0] capCnt_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic en;
  logic master;
  logic pol;
  logic phase;
  logic [LW-1:0] lenField;
  logic [LW-1:0] lenM1;
  logic [LW+1:0] lastEdge;
  logic [WORD_W-1:0] lenMask;
  logic [WORD_W-1:0] nextWord;
  logic mActive;
  logic tick;
  logic [LW+1:0] edgeNum;
  logic mEdge;
  logic mCap;
  logic mLnch;
  logic mDone;
  logic mChain;
  logic mStart;
  logic mLoad;
  logic [LW-1:0] mIdx;
  logic sel;
  logic sCap;
  logic sLnch;
  logic sLoad;
  logic capEv;
  logic wordEnd;
  logic doWrite;
  logic [7:0] wOff;
  logic [7:0] rOff;
  logic wrTx;
  logic rdTake;
  logic rdRx;
  logic [31:0] rdNxt;
  logic [1:0] rrespNxt;

  assign pins.rawClk = serialClockPinIn;
  assign pins.rawSel = frameSelectPinInN;
  assign pins.rawIn = serialInPin;

  sfs_pin_sync uSync
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pins(pins.sync)
  );

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] val, logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = val[8*b +: 8];
    end
    return res;
  endfunction

  // Control decode
  assign en = ctrl_r[sfs_pkg::CTRL_EN];
  assign master = ctrl_r[sfs_pkg::CTRL_MASTER];
  assign pol = ctrl_r[sfs_pkg::CTRL_POL];
  assign phase = ctrl_r[sfs_pkg::CTRL_PHASE];
  assign lenField = ctrl_r[sfs_pkg::CTRL_LEN +: LW];
  assign lenM1 = (lenField < sfs_pkg::LEN_MIN_M1) ? sfs_pkg::LEN_MIN_M1 : lenField;
  assign lastEdge = (LW+2)'({lenM1, 1'b0}) + (LW+2)'(2);
  assign lenMask = WORD_W'((33'h1 << (6'(lenM1) + 6'h01)) - 33'h1);
  assign nextWord = txValid_r ? txWord_r : shWord_r;
  assign mActive = (state_r == sfs_pkg::S_LEAD) || (state_r == sfs_pkg::S_RUN)
                   || (state_r == sfs_pkg::S_TAIL);
  assign sel = !pins.selLvl;

  // Master and slave edge events
  always_comb
  begin
    tick = (halfCnt_r == half_r);
    edgeNum = (state_r == sfs_pkg::S_LEAD) ? (LW+2)'(1) : edgeCnt_r + (LW+2)'(1);
    mEdge = tick && ((state_r == sfs_pkg::S_RUN) || (state_r == sfs_pkg::S_LEAD && phase));
    mCap = mEdge && (edgeNum[0] ^ phase);
    mLnch = mEdge && !mCap && (edgeNum != lastEdge);
    mDone = mEdge && (edgeNum == lastEdge);
    mChain = mDone && phase && txValid_r;
    mStart = (state_r == sfs_pkg::S_IDLE) && en && master && txValid_r;
    mLoad = mStart || mChain;
    mIdx = lenM1 - edgeNum[LW:1];
    sCap = (state_r == sfs_pkg::S_SLAVE) && sel
           && ((pol == phase) ? pins.clkRise : pins.clkFall);
    sLnch = (state_r == sfs_pkg::S_SLAVE) && sel
            && ((pol == phase) ? pins.clkFall : pins.clkRise);
    wordEnd = (capCnt_r == lenM1);
    capEv = mCap || sCap;
    sLoad = (state_r == sfs_pkg::S_SLAVE)
            && (pins.selFall || (sCap && wordEnd && phase));
  end

  // Frame sequencer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= sfs_pkg::S_IDLE;
      halfCnt_r <= 8'h00;
      edgeCnt_r <= '0;
      tailCnt_r <= 1'b0;
      fssN_r <= 1'b1;
    end
    else
    begin
      halfCnt_r <= (tick || !mActive && state_r != sfs_pkg::S_GAP) ? 8'h00 : halfCnt_r + 8'h01;
      if (!en)
      begin
        state_r <= sfs_pkg::S_IDLE;
        fssN_r <= 1'b1;
      end
      else
      begin
        case (state_r)
          sfs_pkg::S_IDLE:
          begin
            if (!master)
              state_r <= sfs_pkg::S_SLAVE;
            else if (mStart)
            begin
              state_r <= sfs_pkg::S_LEAD;
              fssN_r <= 1'b0;
            end
          end
          sfs_pkg::S_LEAD:
          begin
            if (tick)
            begin
              state_r <= sfs_pkg::S_RUN;
              edgeCnt_r <= phase ? (LW+2)'(1) : (LW+2)'(0);
            end
          end
          sfs_pkg::S_RUN:
          begin
            if (mChain)
              edgeCnt_r <= '0;
            else if (mDone)
            begin
              state_r <= sfs_pkg::S_TAIL;
              tailCnt_r <= phase;
            end
            else if (mEdge)
              edgeCnt_r <= edgeNum;
          end
          sfs_pkg::S_TAIL:
          begin
            if (tick && !tailCnt_r)
            begin
              state_r <= sfs_pkg::S_GAP;
              fssN_r <= 1'b1;
            end
            else if (tick)
              tailCnt_r <= 1'b0;
          end
          sfs_pkg::S_GAP:
          begin
            if (tick)
              state_r <= sfs_pkg::S_IDLE;
          end
          sfs_pkg::S_SLAVE:
          begin
            if (master)
              state_r <= sfs_pkg::S_IDLE;
          end
          default:
            state_r <= sfs_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Serial clock
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sclk_r <= 1'b0;
    else if (mActive && mEdge && en)
      sclk_r <= ~sclk_r;
    else if (!mActive || !en)
      sclk_r <= pol;
  end

  // Serial data out, master and slave
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serialOut_r <= 1'b0;
      sOutIdx_r <= '0;
    end
    else if (mActive && en)
    begin
      if ((state_r == sfs_pkg::S_LEAD && tick) || mLnch)
        serialOut_r <= shWord_r[mIdx];
    end
    else if (state_r == sfs_pkg::S_SLAVE && sel)
    begin
      if (pins.selFall)
      begin
        serialOut_r <= nextWord[lenM1];
        sOutIdx_r <= lenM1;
      end
      else if (sLoad)
        sOutIdx_r <= lenM1;
      else if (sLnch && !phase && sOutIdx_r != '0)
      begin
        serialOut_r <= shWord_r[sOutIdx_r - LW'(1)];
        sOutIdx_r <= sOutIdx_r - LW'(1);
      end
      else if (sLnch && phase)
      begin
        serialOut_r <= shWord_r[sOutIdx_r];
        if (sOutIdx_r != '0)
          sOutIdx_r <= sOutIdx_r - LW'(1);
      end
    end
    else
      serialOut_r <= 1'b0;
  end

  // Receive shifter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxShift_r <= '0;
      capCnt_r <= '0;
      rxData_r <= '0;
    end
    else if (state_r == sfs_pkg::S_IDLE || (state_r == sfs_pkg::S_SLAVE && !sel))
      capCnt_r <= '0;
    else if (capEv)
    begin
      rxShift_r <= {rxShift_r[WORD_W-2:0], pins.inLvl};
      capCnt_r <= wordEnd ? '0 : capCnt_r + LW'(1);
      if (wordEnd)
        rxData_r <= {rxShift_r[WORD_W-2:0], pins.inLvl} & lenMask;
    end
  end

  // Receive flag: new word wins over a read
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rxValid_r <= 1'b0;
    else if (capEv && wordEnd)
      rxValid_r <= 1'b1;
    else if (rdRx)
      rxValid_r <= 1'b0;
  end

  // Pending transmit word: write wins over a take
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txWord_r <= '0;
      txValid_r <= 1'b0;
    end
    else if (wrTx)
    begin
      txWord_r <= WORD_W'(merge(32'(txWord_r), wData_r, wStrb_r));
      txValid_r <= 1'b1;
    end
    else if (mLoad || sLoad)
      txValid_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      shWord_r <= '0;
    else if (mLoad || sLoad)
      shWord_r <= nextWord;
  end

  // Register write path
  assign awready = !awHeld_r && !bvalid_r;
  assign wready = !wHeld_r && !bvalid_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign wOff = {awAddr_r[7:2], 2'h0};
  assign wrTx = doWrite && (wOff == sfs_pkg::OFF_TXDATA) && (wStrb_r != 4'h0);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      else if (doWrite)
        awHeld_r <= 1'b0;
      if (wvalid && wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      else if (doWrite)
        wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= sfs_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= (wOff <= sfs_pkg::OFF_STATUS) ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= sfs_pkg::CTRL_RESET;
      half_r <= sfs_pkg::HALF_RESET;
    end
    else if (doWrite && wOff == sfs_pkg::OFF_CTRL)
      ctrl_r <= merge(ctrl_r, wData_r, wStrb_r) & 32'h0000_00FF;
    else if (doWrite && wOff == sfs_pkg::OFF_HALF && wStrb_r[0])
      half_r <= wData_r[7:0];
  end

  // Register read path
  assign arready = !rvalid_r;
  assign rdTake = arvalid && arready;
  assign rOff = {araddr[7:2], 2'h0};
  assign rdRx = rdTake && (rOff == sfs_pkg::OFF_RXDATA);

  always_comb
  begin
    rdNxt = 32'h0000_0000;
    rrespNxt = sfs_pkg::RESP_OKAY;
    case (rOff)
      sfs_pkg::OFF_CTRL: rdNxt = ctrl_r;
      sfs_pkg::OFF_HALF: rdNxt = 32'(half_r);
      sfs_pkg::OFF_TXDATA: rdNxt = 32'(txWord_r);
      sfs_pkg::OFF_RXDATA: rdNxt = 32'(rxData_r);
      sfs_pkg::OFF_STATUS:
      begin
        rdNxt[sfs_pkg::STAT_TXFULL] = txValid_r;
        rdNxt[sfs_pkg::STAT_RXVALID] = rxValid_r;
        rdNxt[sfs_pkg::STAT_BUSY] = mActive || (state_r == sfs_pkg::S_SLAVE && sel);
      end
      default: rrespNxt = sfs_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= sfs_pkg::RESP_OKAY;
    end
    else if (rdTake)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rdNxt;
      rresp_r <= rrespNxt;
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Pads
  assign serialClockPinOut = sclk_r;
  assign serialClockPinOe = master;
  assign frameSelectPinOutN = fssN_r;
  assign frameSelectPinOe = master;
  assign serialOutPin = serialOut_r;
  assign serialOutPinOe = master || (en && state_r == sfs_pkg::S_SLAVE && sel);
endmodule

/* File: pkg/sfs_pkg.sv */
package sfs_pkg;
  localparam int ADDR_W = 8;
  localparam int WORD_MAX = 16;
  localparam int LEN_W = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_HALF = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_POL = 2;
  localparam int CTRL_PHASE = 3;
  localparam int CTRL_LEN = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0070;
  localparam logic [7:0] HALF_RESET = 8'h03;
  localparam logic [LEN_W-1:0] LEN_MIN_M1 = 4'h3;
  localparam int STAT_TXFULL = 0;
  localparam int STAT_RXVALID = 1;
  localparam int STAT_BUSY = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_LEAD = 3'b001,
    S_RUN = 3'b010,
    S_TAIL = 3'b011,
    S_GAP = 3'b100,
    S_SLAVE = 3'b101
  } sfs_state_t;
endpackage

/* File: pkg/sfs_pin_if.sv */
`timescale 1ns/100ps
interface sfs_pin_if;
  logic rawClk;
  logic rawSel;
  logic rawIn;
  logic clkLvl;
  logic selLvl;
  logic inLvl;
  logic clkRise;
  logic clkFall;
  logic selFall;
  modport sync
  (
    input rawClk, rawSel, rawIn,
    output clkLvl, selLvl, inLvl, clkRise, clkFall, selFall
  );
  modport core
  (
    output rawClk, rawSel, rawIn,
    input clkLvl, selLvl, inLvl, clkRise, clkFall, selFall
  );
endinterface

/* File: hw/sfs_pin_sync.sv */
`timescale 1ns/100ps
module sfs_pin_sync
(
  input wire logic sys_clk,
  input wire logic rst_n,
  sfs_pin_if.sync pins
);
  logic [2:0] raw;
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [1:0] prev_r;

  assign raw = {pins.rawIn, pins.rawSel, pins.rawClk};

  // Two flops per pin, first stage read only by the second
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          // Select idles high, so no false select edge after reset
          meta_r[i] <= (i == 1);
          sync_r[i] <= (i == 1);
        end
        else
        begin
          meta_r[i] <= raw[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_r <= 2'h2;
    else
      prev_r <= sync_r[1:0];
  end

  assign pins.clkLvl = sync_r[0];
  assign pins.selLvl = sync_r[1];
  assign pins.inLvl = sync_r[2];
  assign pins.clkRise = sync_r[0] && !prev_r[0];
  assign pins.clkFall = !sync_r[0] && prev_r[0];
  assign pins.selFall = !sync_r[1] && prev_r[1];
endmodule

/* File: dv/sfs_frame_sequencer_asserts.sv */
`timescale 1ns/100ps
module sfs_frame_sequencer_asserts
#(
  parameter int WORD_W = sfs_pkg::WORD_MAX
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [sfs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic serialClockPinOut,
  input wire logic serialClockPinOe,
  input wire logic frameSelectPinOutN,
  input wire logic frameSelectPinOe,
  input wire logic serialOutPin,
  input wire logic serialOutPinOe
);
  logic [sfs_pkg::ADDR_W-1:0] awQ;
  logic [7:0] wQ;
  logic [7:0] ctlR;
  logic [7:0] ctl;
  logic en;
  logic mst;
  logic pol;
  logic pha;
  logic selN;
  logic sck;
  // Control byte as the block sees it, from the cycle bvalid rises
  assign ctl = (bvalid && awQ == sfs_pkg::OFF_CTRL && bresp == sfs_pkg::RESP_OKAY) ?
    wQ : ctlR;
  assign en = ctl[sfs_pkg::CTRL_EN];
  assign mst = ctl[sfs_pkg::CTRL_MASTER];
  assign pol = ctl[sfs_pkg::CTRL_POL];
  assign pha = ctl[sfs_pkg::CTRL_PHASE];
  assign selN = frameSelectPinOutN;
  assign sck = serialClockPinOut;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awQ <= '0;
      wQ <= 8'h00;
    end
    else
    begin
      if (awvalid && awready)
        awQ <= awaddr;
      if (wvalid && wready)
        wQ <= wdata[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctlR <= sfs_pkg::CTRL_RESET[7:0];
    else if (bvalid && bready)
      ctlR <= ctl;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_pad_role: assert property (serialClockPinOe == mst && frameSelectPinOe == mst)
    else $error("pad enable not following role");
  a_idle_levels: assert property (!en && $stable(ctl) |-> selN && !serialOutPin && sck == pol)
    else $error("idle levels wrong");
  a_start_enabled: assert property ($fell(selN) |-> $past(en && mst))
    else $error("frame started while off");
  a_frame_drives: assert property (mst && en && !selN |-> serialOutPinOe)
    else $error("data out not driven in frame");
  a_lead_phase0: assert property ($fell(selN) && !pha |-> (sck == pol) [*8] ##1 sck != pol)
    else $error("phase zero lead wrong");
  a_lead_phase1: assert property ($fell(selN) && pha |-> (sck == pol) [*4] ##1 sck != pol)
    else $error("phase one lead wrong");
  a_launch_phase0: assert property (mst && !pha && !selN && $past(!selN) && $changed(serialOutPin)
    |-> sck == pol)
    else $error("data moved on capture edge");
  a_launch_phase1: assert property (mst && pha && !selN && $past(!selN) && $changed(serialOutPin)
    |-> sck != pol && $changed(sck))
    else $error("data moved off launch edge");
  a_tail_phase0: assert property ($rose(selN) && mst && en && !pha
    |-> $past(sck, 4) == pol && $past(sck, 5) != pol)
    else $error("phase zero select release late or early");
  a_tail_phase1: assert property ($rose(selN) && mst && en && pha
    |-> $past(sck, 8) == pol && $past(sck, 9) != pol)
    else $error("phase one select release late or early");
  a_gap_pulse: assert property ($rose(selN) && mst && en && !pha |-> selN [*4])
    else $error("select gap too short");
  c_phase1_frame: cover property ($fell(selN) && pha);
  c_phase0_gap: cover property ($rose(selN) && en && !pha);
  c_abort: cover property ($rose(selN) && !en);
endmodule

bind sfs_frame_sequencer sfs_frame_sequencer_asserts #(.WORD_W(WORD_W))
  sfs_frame_sequencer_asserts_i (.sys_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
  .wvalid, .wready, .bresp, .bvalid, .bready, .serialClockPinOut, .serialClockPinOe,
  .frameSelectPinOutN, .frameSelectPinOe, .serialOutPin, .serialOutPinOe);

/* File: dv/sfs_spi_partner.sv */
`timescale 1ns/100ps
module sfs_spi_partner
(
  input wire logic sck,
  input wire logic selN,
  input wire logic mosi,
  input wire logic pol,
  input wire logic pha,
  input wire logic [4:0] nBits,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] rxWord,
  output int nWords
);
  logic [15:0] sh;
  logic [15:0] rxSh;
  int cnt;
  initial
  begin
    miso = 1'b0;
    rxWord = 16'h0000;
    rxSh = 16'h0000;
    sh = 16'h0000;
    nWords = 0;
    cnt = 0;
  end
  // Word taken at select fall; phase one takes it again at the first launch edge of each word
  always @(negedge selN)
  begin
    sh = reply;
    cnt = 0;
    if (!pha)
      miso = reply[nBits-1];
  end
  // Released line shows the inverse of its last value
  always @(posedge selN)
    miso = ~miso;
  always @(sck)
  begin
    if (!selN && ((sck != pol) ^ pha))
    begin
      rxSh = {rxSh[14:0], mosi};
      cnt++;
      if (cnt == nBits)
      begin
        rxWord = rxSh & ((16'h0001 << nBits) - 16'h0001);
        nWords++;
        cnt = 0;
      end
    end
    else if (!selN && (pha || cnt != 0))
    begin
      if (pha && cnt == 0)
        sh = reply;
      miso = sh[nBits-1-cnt];
    end
  end
endmodule

/* File: dv/sfs_frame_sequencer_tb.sv */
`timescale 1ns/100ps
module sfs_frame_sequencer_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic serialClockPinOut;
  logic serialClockPinOe;
  logic frameSelectPinOutN;
  logic frameSelectPinOe;
  logic serialOutPin;
  logic serialOutPinOe;
  logic miso;
  logic pol = 1'b0;
  logic pha = 1'b0;
  logic [4:0] nBits = 5'h08;
  logic [15:0] reply = 16'h0;
  logic [15:0] rxWord;
  int nWords;
  logic sckW;
  logic selW;
  logic mosiW;
  logic mSck = 1'b0;
  logic mSel = 1'b1;
  int n_mismatch = 0;
  int n_checks = 0;
  int nFalls = 0;
  int nSeen = 0;
  logic [33:0] rdQ[$];
  logic [1:0] bQ[$];
  logic [15:0] wordQ[$];
  always #5 sys_clk = ~sys_clk;
  // Bench is link master while the pads are off; select idles high
  assign sckW = serialClockPinOe ? serialClockPinOut : mSck;
  assign selW = frameSelectPinOe ? frameSelectPinOutN : mSel;
  assign mosiW = serialOutPinOe ? serialOutPin : 1'b0;
  sfs_frame_sequencer sfs_frame_sequencer_i (.sys_clk, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .serialClockPinIn(sckW), .serialClockPinOut,
    .serialClockPinOe, .frameSelectPinInN(selW), .frameSelectPinOutN, .frameSelectPinOe,
    .serialOutPin, .serialOutPinOe, .serialInPin(miso));
  sfs_spi_partner sfs_spi_partner_i (.sck(sckW), .selN(selW), .mosi(mosiW), .pol, .pha,
    .nBits, .reply, .miso, .rxWord, .nWords);
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo;
    n_mismatch++;
    $display("[FAIL] wait ran out");
    wrap_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t = 0;
    bQ.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      t++;
    end
    while (!bvalid && t < 50);
    bready <= 1'b0;
    @(posedge sys_clk);
    if (t >= 50)
      tmo();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int t = 0;
    rdQ.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready)
        arvalid <= 1'b0;
      t++;
    end
    while (!rvalid && t < 50);
    rready <= 1'b0;
    @(posedge sys_clk);
    if (t >= 50)
      tmo();
  endtask
  always @(posedge sys_clk)
  begin
    if (bvalid && bready)
      chk("bresp", {32'h0, bresp}, {32'h0, bQ.pop_front()});
    if (rvalid && rready)
      chk("read", {rresp, rdata}, rdQ.pop_front());
    if (nWords != nSeen)
    begin
      nSeen = nWords;
      chk("word", {18'h0, rxWord}, {18'h0, wordQ.pop_front()});
    end
  end
  always @(negedge frameSelectPinOutN)
    nFalls++;
  initial
  begin
    int t;
    int len;
    int f0;
    logic [31:0] c;
    logic [31:0] msk;
    logic [31:0] d;
    logic [15:0] r;
    void'($urandom(32'hDD4CC249));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("idle pins", {serialClockPinOut, frameSelectPinOutN, serialOutPin, serialClockPinOe},
      4'b0100);
    rd(sfs_pkg::OFF_CTRL, {sfs_pkg::RESP_OKAY, sfs_pkg::CTRL_RESET});
    rd(sfs_pkg::OFF_HALF, {sfs_pkg::RESP_OKAY, 24'h0, sfs_pkg::HALF_RESET});
    rd(8'h14, {sfs_pkg::RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h0000_00FF, sfs_pkg::RESP_SLVERR);
    for (int m = 0; m < 4; m++)
    begin
      len = 4 + $urandom % 13;
      msk = (32'h1 << len) - 32'h1;
      r = $urandom;
      pol <= m[0];
      pha <= m[1];
      nBits <= len[4:0];
      reply <= r;
      c = 32'(((len - 1) << sfs_pkg::CTRL_LEN) | (m << sfs_pkg::CTRL_POL) | 3);
      wr(sfs_pkg::OFF_CTRL, c & 32'hFFFF_FFFE, sfs_pkg::RESP_OKAY);
      wr(sfs_pkg::OFF_CTRL, c, sfs_pkg::RESP_OKAY);
      chk("clock pad", serialClockPinOe, 1'b1);
      f0 = nFalls;
      for (int k = 0; k < 2; k++)
      begin
        d = $urandom & msk;
        wordQ.push_back(d[15:0]);
        wr(sfs_pkg::OFF_TXDATA, d, sfs_pkg::RESP_OKAY);
      end
      t = 0;
      while ((nWords < nSeen + wordQ.size() || !frameSelectPinOutN) && t < 3000)
      begin
        @(posedge sys_clk);
        t++;
      end
      if (t >= 3000)
        tmo();
      chk("idle clock", serialClockPinOut, m[0]);
      chk("select falls", nFalls - f0, m[1] ? 1 : 2);
      rd(sfs_pkg::OFF_RXDATA, {sfs_pkg::RESP_OKAY, 16'h0, r & msk[15:0]});
    end
    pol <= 1'b0;
    pha <= 1'b0;
    nBits <= 5'h10;
    wr(sfs_pkg::OFF_CTRL, 32'h0000_00F3, sfs_pkg::RESP_OKAY);
    wr(sfs_pkg::OFF_TXDATA, 32'h0000_9C3A, sfs_pkg::RESP_OKAY);
    repeat (30) @(posedge sys_clk);
    wr(sfs_pkg::OFF_CTRL, 32'h0000_00F2, sfs_pkg::RESP_OKAY);
    chk("abort select", frameSelectPinOutN, 1'b1);
    f0 = nFalls;
    wr(sfs_pkg::OFF_TXDATA, 32'h0000_0005, sfs_pkg::RESP_OKAY);
    repeat (100) @(posedge sys_clk);
    chk("no frame while off", nFalls - f0, 0);
    // Slave frame: bench makes clock and select, partner answers
    nBits <= 5'h08;
    r = $urandom;
    reply <= r;
    d = $urandom & 32'hFF;
    wordQ.push_back(d[15:0]);
    wr(sfs_pkg::OFF_CTRL, 32'h0000_0071, sfs_pkg::RESP_OKAY);
    wr(sfs_pkg::OFF_TXDATA, d, sfs_pkg::RESP_OKAY);
    chk("slave pads", {serialClockPinOe, frameSelectPinOe, serialOutPinOe}, 3'b000);
    mSel <= 1'b0;
    repeat (8)
    begin
      repeat (4) @(posedge sys_clk);
      mSck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      mSck <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    mSel <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(sfs_pkg::OFF_RXDATA, {sfs_pkg::RESP_OKAY, 24'h0, r[7:0]});
    wrap_up();
  end
endmodule
